// >>> verilog/ldsf_pkg.sv
/*
 * Package for the event status flag block: register offsets, bit positions,
 * reset values, bus encodings, the receive suspension state and the carriers
 * for event strobes and descriptor actions.
 * Assumes a single 200 MHz clock domain shared by the block and its sources.
 */
package ldsf_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_PORT_CONTROL = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_ENGINE_STATE = 8'h0C;

	// ------------------------------------------------------------------
	// Status fields
	// ------------------------------------------------------------------
	localparam int SYSTEM_ERROR_BIT = 13;
	localparam int LINK_FAIL_BIT = 12;
	localparam int TIMER_EXPIRED_BIT = 11;
	localparam int RX_WATCHDOG_BIT = 9;
	localparam int RX_STOPPED_BIT = 8;
	localparam int RX_BUF_UNAVAIL_BIT = 7;
	localparam int RX_COMPLETE_BIT = 6;
	localparam int TX_UNDERFLOW_BIT = 5;
	localparam int NORMAL_SUMMARY_BIT = 16;
	localparam int ABNORMAL_SUMMARY_BIT = 15;
	localparam logic [31:0] FLAG_BITS = 32'h0000_3BE0;
	localparam logic [31:0] NORMAL_BITS = 32'h0000_0840;
	localparam logic [31:0] ABNORMAL_BITS = 32'h0000_33A0;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Port control and engine state fields
	// ------------------------------------------------------------------
	localparam int CTL_SQUELCH_EN_BIT = 0;
	localparam int CTL_PORT_AUI_BIT = 1;
	localparam int CTL_FORCE_LINK_FAIL_BIT = 2;
	localparam logic [31:0] CTL_BITS = 32'h0000_0007;
	localparam logic [31:0] CTL_RESET = 32'h0000_0000;
	localparam int ST_DMA_ENABLE_BIT = 0;
	localparam int ST_RX_SUSPENDED_BIT = 1;
	localparam int ST_RU_ARMED_BIT = 2;

	// ------------------------------------------------------------------
	// Bus encodings
	// ------------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic HRESP_OKAY = 1'h0;

	typedef enum logic [1:0] {
		LDSF_RX_RUNNING = 2'b00,
		LDSF_RX_SUSPENDED = 2'b01
	} ldsf_rx_e;

	typedef struct packed {
		logic system_error;
		logic link_fail;
		logic timer_expired;
		logic rx_watchdog;
		logic rx_stopped;
		logic rx_desc_not_owned;
		logic rx_desc_owned;
		logic rx_frame_done;
		logic tx_underflow;
		logic rx_poll_demand;
		logic rx_frame_seen;
	} ldsf_event_s;

	typedef struct packed {
		logic rx_abort;
		logic rdes_length_error;
		logic rdes_last_desc;
		logic tx_suspend;
		logic tdes_underflow;
	} ldsf_action_s;

endpackage : ldsf_pkg

// >>> verilog/ldsf_status_flags.sv
/*
 * Event status flags of the LAN controller with their mask, interrupt,
 * port control and engine state registers, reached over an AHB-Lite slave.
 * Assumes the event strobes come from logic on the same clock, one cycle each,
 * and that rst doubles as the software reset.
 * Assumes the one slave's hreadyout is fed back as hready and that only single
 * whole-word transfers arrive, so hsize needs no decode.
 * Every output leaves through a flop or is a constant of the bus protocol.
 */
`timescale 1ns/100ps

module ldsf_status_flags (
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire ldsf_pkg::ldsf_event_s events,
	output ldsf_pkg::ldsf_action_s actions,
	output logic dma_enable,
	output logic rx_suspended,
	output logic squelch_enable,
	output logic port_aui_select,
	output logic irq
);
	import ldsf_pkg::*;

	// ------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------
	logic wr_pend_ff;
	logic nxt_wr_pend_ff;
	logic [ADDR_W-1:0] wr_addr_ff;
	logic [ADDR_W-1:0] nxt_wr_addr_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] nxt_hrdata_ff;
	logic addr_phase;
	logic wr_status;
	logic wr_mask;
	logic wr_ctl;

	// Only whole-word transfers are issued, so hsize needs no decode.
	assign addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ | htrans == HTRANS_SEQ);
	assign wr_status = wr_pend_ff & (wr_addr_ff == ADDR_EVENT_STATUS);
	assign wr_mask = wr_pend_ff & (wr_addr_ff == ADDR_EVENT_MASK);
	assign wr_ctl = wr_pend_ff & (wr_addr_ff == ADDR_PORT_CONTROL);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [31:0] status_ff;
	logic [31:0] nxt_status_ff;
	logic [31:0] mask_ff;
	logic [31:0] nxt_mask_ff;
	logic [31:0] ctl_ff;
	logic [31:0] nxt_ctl_ff;
	logic [31:0] flag_set;
	logic [31:0] flag_clr;
	logic [31:0] status_view;
	logic [31:0] state_view;
	logic link_fail_qualified;
	logic force_link_fail;
	logic ru_armed_ff;
	logic nxt_ru_armed_ff;
	ldsf_rx_e rx_state_ff;
	ldsf_rx_e nxt_rx_state_ff;
	ldsf_action_s actions_ff;
	ldsf_action_s nxt_actions_ff;
	logic dma_enable_ff;
	logic irq_ff;
	logic nxt_dma_enable_ff;
	logic nxt_irq_ff;
	logic rx_suspended_ff;
	logic nxt_rx_suspended_ff;

	// The qualifier reads the control bits as they stand, so a new setting acts a cycle later.
	assign link_fail_qualified = events.link_fail & ctl_ff[CTL_SQUELCH_EN_BIT]
		& ~ctl_ff[CTL_PORT_AUI_BIT];
	assign force_link_fail = wr_ctl & hwdata[CTL_FORCE_LINK_FAIL_BIT];

	// ------------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------------
	// A set and a clear in one cycle leave the flag set, so no event is lost to a late clear.
	always_comb begin
		flag_set = 32'h0000_0000;
		flag_set[SYSTEM_ERROR_BIT] = events.system_error;
		flag_set[LINK_FAIL_BIT] = link_fail_qualified | force_link_fail;
		flag_set[TIMER_EXPIRED_BIT] = events.timer_expired;
		flag_set[RX_WATCHDOG_BIT] = events.rx_watchdog;
		flag_set[RX_STOPPED_BIT] = events.rx_stopped;
		flag_set[RX_BUF_UNAVAIL_BIT] = events.rx_desc_not_owned & ru_armed_ff;
		flag_set[RX_COMPLETE_BIT] = events.rx_frame_done | events.rx_watchdog;
		flag_set[TX_UNDERFLOW_BIT] = events.tx_underflow;
		flag_clr = wr_status ? hwdata : 32'h0000_0000;
	end

	// Each flag is independent; bits outside the flag set stay at zero.
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_flag
			if (FLAG_BITS[gi]) begin : g_live
				assign nxt_status_ff[gi] = flag_set[gi] | (status_ff[gi] & ~flag_clr[gi]);
			end else begin : g_dead
				assign nxt_status_ff[gi] = STATUS_RESET[gi];
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (rst) begin
			status_ff <= STATUS_RESET;
		end else begin
			status_ff <= nxt_status_ff;
		end
	end

	// ------------------------------------------------------------------
	// Read views
	// ------------------------------------------------------------------
	// The summaries are read-only views; a write to them does nothing.
	always_comb begin
		status_view = nxt_status_ff;
		status_view[NORMAL_SUMMARY_BIT] = |(nxt_status_ff & nxt_mask_ff & NORMAL_BITS);
		status_view[ABNORMAL_SUMMARY_BIT] = |(nxt_status_ff & nxt_mask_ff & ABNORMAL_BITS);
		state_view = 32'h0000_0000;
		state_view[ST_DMA_ENABLE_BIT] = ~nxt_status_ff[SYSTEM_ERROR_BIT];
		state_view[ST_RX_SUSPENDED_BIT] = (nxt_rx_state_ff == LDSF_RX_SUSPENDED);
		state_view[ST_RU_ARMED_BIT] = nxt_ru_armed_ff;
	end

	// ------------------------------------------------------------------
	// Mask and port control
	// ------------------------------------------------------------------
	// A force link fail write is stored like the other bits but acts only on the write itself.
	always_comb begin
		nxt_mask_ff = wr_mask ? (hwdata & FLAG_BITS) : mask_ff;
		nxt_ctl_ff = wr_ctl ? (hwdata & CTL_BITS) : ctl_ff;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			mask_ff <= MASK_RESET;
			ctl_ff <= CTL_RESET;
		end else begin
			mask_ff <= nxt_mask_ff;
			ctl_ff <= nxt_ctl_ff;
		end
	end

	// ------------------------------------------------------------------
	// Receive suspension and buffer-unavailable arming
	// ------------------------------------------------------------------
	// A host-owned fetch while suspended keeps reception suspended until it is woken.
	always_comb begin
		nxt_rx_state_ff = rx_state_ff;
		case (rx_state_ff)
			LDSF_RX_RUNNING: begin
				if (events.rx_desc_not_owned) begin
					nxt_rx_state_ff = LDSF_RX_SUSPENDED;
				end
			end
			LDSF_RX_SUSPENDED: begin
				if (events.rx_poll_demand | events.rx_frame_seen) begin
					nxt_rx_state_ff = LDSF_RX_RUNNING;
				end
			end
			default: begin
				nxt_rx_state_ff = LDSF_RX_RUNNING;
			end
		endcase
	end

	// A watchdog abort leaves the receive state untouched, so it keeps running.
	always_ff @(posedge clock) begin
		if (rst) begin
			rx_state_ff <= LDSF_RX_RUNNING;
		end else begin
			rx_state_ff <= nxt_rx_state_ff;
		end
	end

	// Arming follows the last fetch outcome, so a run of host-owned fetches flags once.
	always_comb begin
		if (events.rx_desc_owned) begin
			nxt_ru_armed_ff = 1'b1;
		end else if (events.rx_desc_not_owned) begin
			nxt_ru_armed_ff = 1'b0;
		end else begin
			nxt_ru_armed_ff = ru_armed_ff;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ru_armed_ff <= 1'b1;
		end else begin
			ru_armed_ff <= nxt_ru_armed_ff;
		end
	end

	// ------------------------------------------------------------------
	// Descriptor actions and status outputs
	// ------------------------------------------------------------------
	// Strobes and levels leave through flops, a cycle after their cause.
	always_comb begin
		nxt_actions_ff.rx_abort = events.rx_watchdog;
		nxt_actions_ff.rdes_length_error = events.rx_watchdog;
		nxt_actions_ff.rdes_last_desc = events.rx_watchdog;
		nxt_actions_ff.tx_suspend = events.tx_underflow;
		nxt_actions_ff.tdes_underflow = events.tx_underflow;
		nxt_dma_enable_ff = ~nxt_status_ff[SYSTEM_ERROR_BIT];
		nxt_rx_suspended_ff = (nxt_rx_state_ff == LDSF_RX_SUSPENDED);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			actions_ff <= '0;
			dma_enable_ff <= 1'b1;
			rx_suspended_ff <= 1'b0;
		end else begin
			actions_ff <= nxt_actions_ff;
			dma_enable_ff <= nxt_dma_enable_ff;
			rx_suspended_ff <= nxt_rx_suspended_ff;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------------
	// The level follows next values, so it rises on the edge that sets the flag.
	always_comb begin
		nxt_irq_ff = |(nxt_status_ff & nxt_mask_ff);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq_ff;
		end
	end

	// ------------------------------------------------------------------
	// Bus slave data path
	// ------------------------------------------------------------------
	// Write data trails its address phase by a cycle, so the address waits in a flop.
	always_comb begin
		nxt_wr_pend_ff = addr_phase & hwrite;
		nxt_wr_addr_ff = addr_phase ? haddr[ADDR_W-1:0] : wr_addr_ff;
		// Read data comes from next values so a read right after a write sees it.
		nxt_hrdata_ff = 32'h0000_0000;
		if (addr_phase & ~hwrite) begin
			case (haddr[ADDR_W-1:0])
				ADDR_EVENT_STATUS: nxt_hrdata_ff = status_view;
				ADDR_EVENT_MASK: nxt_hrdata_ff = nxt_mask_ff;
				ADDR_PORT_CONTROL: nxt_hrdata_ff = nxt_ctl_ff;
				ADDR_ENGINE_STATE: nxt_hrdata_ff = state_view;
				default: nxt_hrdata_ff = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= '0;
			hrdata_ff <= 32'h0000_0000;
		end else begin
			wr_pend_ff <= nxt_wr_pend_ff;
			wr_addr_ff <= nxt_wr_addr_ff;
			hrdata_ff <= nxt_hrdata_ff;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign hrdata = hrdata_ff;
	assign actions = actions_ff;
	assign dma_enable = dma_enable_ff;
	assign rx_suspended = rx_suspended_ff;
	assign squelch_enable = ctl_ff[CTL_SQUELCH_EN_BIT];
	assign port_aui_select = ctl_ff[CTL_PORT_AUI_BIT];
	assign irq = irq_ff;

endmodule : ldsf_status_flags

// >>> test/ldsf_asserts.sv
/*
 * Checker for the event status flag block: event to action, DMA and
 * receive suspension relations. Assumes one clock and synchronous rst.
 */
`timescale 1ns/100ps
module ldsf_asserts (
	input wire logic clock,
	input wire logic rst,
	input wire ldsf_pkg::ldsf_event_s events,
	input wire ldsf_pkg::ldsf_action_s actions,
	input wire logic dma_enable,
	input wire logic rx_suspended
);
	import ldsf_pkg::*;
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	underflow_act_a: assert property (events.tx_underflow |=>
		actions.tx_suspend && actions.tdes_underflow) else $error("underflow action missing");
	watchdog_act_a: assert property (events.rx_watchdog |=> actions.rx_abort &&
		actions.rdes_length_error && actions.rdes_last_desc) else $error("abort marks missing");
	abort_cause_a: assert property (actions.rx_abort |->
		$past(events.rx_watchdog)) else $error("abort without watchdog");
	suspend_cause_a: assert property (actions.tx_suspend |->
		$past(events.tx_underflow)) else $error("suspend without underflow");
	sys_err_a: assert property (events.system_error |=> !dma_enable)
		else $error("dma still enabled");
	dma_back_a: assert property ($rose(dma_enable) |->
		!$past(events.system_error)) else $error("dma resumed on error");
	rx_susp_a: assert property (events.rx_desc_not_owned && !events.rx_poll_demand &&
		!events.rx_frame_seen |=> rx_suspended) else $error("reception not suspended");
	resume_a: assert property (rx_suspended && !events.rx_desc_not_owned &&
		(events.rx_poll_demand || events.rx_frame_seen) |=> !rx_suspended) else $error("no resume");
	wdog_run_a: assert property (!rx_suspended && events.rx_watchdog &&
		!events.rx_desc_not_owned |=> !rx_suspended) else $error("watchdog stopped reception");
	cover property (events.tx_underflow);
	cover property (rx_suspended ##1 !rx_suspended);
	cover property (!dma_enable);
endmodule : ldsf_asserts

bind ldsf_status_flags ldsf_asserts u_chk (.clock, .rst, .events, .actions, .dma_enable,
	.rx_suspended);

// >>> test/ldsf_host_model.sv
/*
 * Host processor model: an AHB-Lite master doing single word transfers.
 * Assumes the one slave's hreadyout is fed back as hready.
 */
`timescale 1ns/100ps
module ldsf_host_model (
	input wire logic clock,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	import ldsf_pkg::*;
	initial begin
		hsel = 0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 0;
		hsize = 3'h2;
		hwdata = '0;
	end
	// Called just after a rising edge; waits as long as the slave stalls.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1;
		haddr <= {24'h00_0000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 0;
		hwdata <= w ? d : ~hwdata;
		do @(posedge clock); while (hready !== 1'b1);
		r = hrdata;
		hwdata <= ~d;
	endtask : xfer
endmodule : ldsf_host_model

// >>> test/test_lan_dma_status_flags.sv
/*
 * Self-checking bench for the event status flags over AHB-Lite.
 * Assumes the host model and the bound checker are compiled with it.
 */
`timescale 1ns/100ps
module test_lan_dma_status_flags;
	import ldsf_pkg::*;
	logic clock = 0, rst = 1, hready, hresp, hsel, hwrite, irq;
	logic dma_enable, rx_suspended, squelch_enable, port_aui_select;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, r;
	ldsf_event_s ev = '0;
	int err_count = 0, compares = 0;
	always #2.5 clock = ~clock;
	ldsf_host_model host (.clock, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata);
	ldsf_status_flags DUT (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout(hready), .hresp, .hrdata, .events(ev), .actions(),
		.dma_enable, .rx_suspended, .squelch_enable, .port_aui_select, .irq);
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		compares++;
		if (s !== e) begin
			$display("Error %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [31:0] d);
		host.xfer(1, a, d, r);
	endtask : wr
	task automatic rdc(logic [7:0] a, logic [31:0] e);
		host.xfer(0, a, 32'h0000_0000, r);
		chk("register", r, e);
	endtask : rdc
	task automatic pulse(int i);
		ev[i] <= 1;
		@(posedge clock);
		ev <= '0;
		@(posedge clock);
	endtask : pulse
	task automatic complete_run();
		if (err_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		rdc(ADDR_EVENT_STATUS, 32'h0000_0000);
		rdc(ADDR_EVENT_MASK, 32'h0000_0000);
		rdc(ADDR_ENGINE_STATE, 32'h0000_0005);
		rdc(8'h10, 32'h0000_0000);
		chk("hresp", hresp, HRESP_OKAY);
		chk("hready", hready, 1'b1);
	endtask : t_reset
	task automatic t_flags();
		int idx[7] = '{10, 9, 8, 7, 6, 3, 2};
		logic [31:0] ex[7] = '{32'h0000_2000, 32'h0000_1000, 32'h0000_0800, 32'h0000_0240,
			32'h0000_0100, 32'h0000_0040, 32'h0000_0020};
		wr(ADDR_PORT_CONTROL, 32'h0000_0001);
		for (int i = 0; i < 7; i++) begin
			pulse(idx[i]);
			chk("dma_enable", dma_enable, i != 0);
			rdc(ADDR_EVENT_STATUS, ex[i]);
			rdc(ADDR_EVENT_STATUS, ex[i]);
			wr(ADDR_EVENT_STATUS, 32'h0000_0000);
			rdc(ADDR_EVENT_STATUS, ex[i]);
			wr(ADDR_EVENT_STATUS, ex[i]);
			rdc(ADDR_EVENT_STATUS, 32'h0000_0000);
			chk("dma_enable", dma_enable, 1);
		end
	endtask : t_flags
	task automatic t_irq();
		wr(ADDR_EVENT_MASK, 32'h0000_0020);
		pulse(2);
		chk("irq", irq, 1);
		rdc(ADDR_EVENT_STATUS, 32'h0000_8020);
		wr(ADDR_EVENT_STATUS, 32'h0000_0020);
		@(posedge clock);
		chk("irq", irq, 0);
		wr(ADDR_EVENT_MASK, 32'h0000_0000);
		pulse(2);
		chk("irq", irq, 0);
		fork
			wr(ADDR_EVENT_STATUS, 32'h0000_0020);
			begin
				@(posedge clock);
				ev[2] <= 1;
				@(posedge clock);
				ev <= '0;
			end
		join
		rdc(ADDR_EVENT_STATUS, 32'h0000_0020);
		wr(ADDR_EVENT_STATUS, 32'h0000_0020);
		wr(ADDR_EVENT_MASK, 32'h0000_0040);
		pulse(3);
		rdc(ADDR_EVENT_STATUS, 32'h0001_0040);
		wr(ADDR_EVENT_STATUS, 32'h0000_0040);
		wr(ADDR_EVENT_MASK, 32'h0000_0000);
		rdc(ADDR_EVENT_STATUS, 32'h0000_0000);
	endtask : t_irq
	task automatic t_ru();
		pulse(5);
		chk("rx_suspended", rx_suspended, 1);
		rdc(ADDR_EVENT_STATUS, 32'h0000_0080);
		rdc(ADDR_ENGINE_STATE, 32'h0000_0003);
		wr(ADDR_EVENT_STATUS, 32'h0000_0080);
		pulse(5);
		rdc(ADDR_EVENT_STATUS, 32'h0000_0000);
		pulse(1);
		chk("rx_suspended", rx_suspended, 0);
		pulse(4);
		pulse(5);
		rdc(ADDR_EVENT_STATUS, 32'h0000_0080);
		pulse(0);
		chk("rx_suspended", rx_suspended, 0);
		wr(ADDR_EVENT_STATUS, 32'h0000_0080);
	endtask : t_ru
	task automatic t_link();
		wr(ADDR_PORT_CONTROL, 32'h0000_0003);
		@(posedge clock);
		chk("aui", {squelch_enable, port_aui_select}, 2'b11);
		rdc(ADDR_PORT_CONTROL, 32'h0000_0003);
		pulse(9);
		rdc(ADDR_EVENT_STATUS, 32'h0000_0000);
		wr(ADDR_PORT_CONTROL, 32'h0000_0004);
		rdc(ADDR_EVENT_STATUS, 32'h0000_1000);
		wr(ADDR_EVENT_MASK, 32'h0000_3000);
		pulse(10);
		chk("irq", irq, 1);
		rdc(ADDR_EVENT_STATUS, 32'h0000_B000);
		wr(ADDR_EVENT_STATUS, 32'h0000_3000);
		rdc(ADDR_EVENT_STATUS, 32'h0000_0000);
	endtask : t_link
	task automatic t_soft_reset();
		pulse(10);
		chk("dma_enable", dma_enable, 0);
		rst <= 1;
		repeat (2) @(posedge clock);
		rst <= 0;
		@(posedge clock);
		chk("dma_enable", dma_enable, 1);
		rdc(ADDR_EVENT_STATUS, 32'h0000_0000);
		rdc(ADDR_ENGINE_STATE, 32'h0000_0005);
	endtask : t_soft_reset
	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clock);
		rst <= 0;
		@(posedge clock);
		t_reset();
		t_flags();
		t_irq();
		t_ru();
		t_link();
		t_soft_reset();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		complete_run();
	end
endmodule : test_lan_dma_status_flags
